// file: inc/ipr_pkg.sv
package ipr_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  // ==========================================================================
  // Register map
  localparam logic [ADDR_W-1:0] PULLUP_LOW_ADDR = 20'h003F0;
  localparam logic [ADDR_W-1:0] SERIAL_ROUTE_ADDR = 20'h4009D;
  localparam logic [ADDR_W-1:0] LIN_ROUTE_ADDR = 20'h4009E;

  localparam logic [DATA_W-1:0] PULLUP_LOW_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SERIAL_ROUTE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] LIN_ROUTE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int SERIAL_SEL_BIT = 0;
  localparam int SERIAL_RSV_BIT = 4;
  localparam int LIN_SEL_LO = 0;
  localparam int LIN_SEL_HI = 1;
  localparam int LIN_RSV_LO = 2;
  localparam int LIN_RSV_HI = 3;
  localparam logic [DATA_W-1:0] SERIAL_IMPL_MASK = 8'h11;
  localparam logic [DATA_W-1:0] LIN_IMPL_MASK = 8'h0F;

  // ==========================================================================
  // Pull-up grouping
  localparam int PINS_PER_GROUP = 4;
  localparam int GROUP_CNT = 8;
  localparam int PORT_PIN_CNT = 32;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    IPR_LIN_P3_1 = 2'b00,
    IPR_LIN_P4_5 = 2'b01,
    IPR_LIN_P7_5 = 2'b10,
    IPR_LIN_FORBID = 2'b11
  } ipr_lin_sel_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ipr_bus_req_s;

  typedef struct packed {
    logic serialSel;
    logic serialRsv;
    ipr_lin_sel_e linSel;
    logic [1:0] linRsv;
    logic [GROUP_CNT-1:0] pullupCtl;
  } ipr_cfg_s;

endpackage

// file: logic/ipr_pullup_groups.sv
`timescale 1ns/1ps
module ipr_pullup_groups
  import ipr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [GROUP_CNT-1:0] groupCtl,
  input wire logic [PORT_PIN_CNT-1:0] portDir,
  output logic [PORT_PIN_CNT-1:0] pullupEnable
);

  // ==========================================================================
  // Group expansion
  // One control bit fans out to four adjacent pins; there is no per-pin control.
  logic [PORT_PIN_CNT-1:0] groupSpread;
  logic [PORT_PIN_CNT-1:0] pullupEnable_nxt;
  logic [PORT_PIN_CNT-1:0] pullupEnable_r;

  for (genvar g = 0; g < GROUP_CNT; g++) begin : gGroup
    assign groupSpread[g*PINS_PER_GROUP +: PINS_PER_GROUP] =
      {PINS_PER_GROUP{groupCtl[g]}};
  end

  // An output pin never gets a pull-up, whatever its group bit says.
  assign pullupEnable_nxt = groupSpread & ~portDir;

  always_ff @(posedge clock) begin
    if (rst) begin
      pullupEnable_r <= '0;
    end else if (ce) begin
      pullupEnable_r <= pullupEnable_nxt;
    end
  end

  assign pullupEnable = pullupEnable_r;

  // ==========================================================================
  // Checks
  a_pullup_group_equal: assert property (@(posedge clock) disable iff (rst)
    ce && portDir == '0 |=> pullupEnable[3:0] == {4{pullupEnable[0]}})
    else $error("Pins of one pull-up group disagree.");

  a_pullup_bit_value: assert property (@(posedge clock) disable iff (rst)
    ce && portDir == '0 && groupCtl == 8'h00 |=> pullupEnable == 32'h00000000)
    else $error("Pull-up active with all group bits cleared.");

  a_pullup_output_off: assert property (@(posedge clock) disable iff (rst)
    ce && groupCtl == 8'hFF |=> pullupEnable == ~$past(portDir))
    else $error("Pull-up does not follow pin direction.");

  a_pullup_bit_order: assert property (@(posedge clock) disable iff (rst)
    ce && portDir == '0 && groupCtl == 8'h82 |=> pullupEnable == 32'hF00000F0)
    else $error("Pull-up group bits mapped to wrong pins.");

endmodule // ipr_pullup_groups

// file: logic/ipr_input_route.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Serial-bus input comes from port one when select is 0, port four when 1.
// - LIN receive select 00 picks P3 bit1, 01 P4 bit5, 10 P7 bit5.
// - Upper unimplemented routing bits are written zero; reads return zero here.
// - Each pull-up bit governs one group of four adjacent pins.
// - Pull-up bit 0 disables the group's pull-ups, 1 enables them.
// - A pull-up is active only with group bit 1 and direction bit 0.
// - Pull-up bits zero to seven map to halves of ports zero to three.
module ipr_input_route
  import ipr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic [DATA_W-1:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [DATA_W-1:0] busRdata,
  input wire logic serialInPort1,
  input wire logic serialInPort4,
  input wire logic linRxPort3Pin1,
  input wire logic linRxPort4Pin5,
  input wire logic linRxPort7Pin5,
  input wire logic [PORT_PIN_CNT-1:0] portDir,
  output logic serialBusInput,
  output logic linReceiveInput,
  output logic [PORT_PIN_CNT-1:0] pullupEnable
);

  // ==========================================================================
  // Selection functions
  // The forbidden LIN pattern parks the input low, so no pin can reach it.
  function automatic logic linPick(input ipr_lin_sel_e sel, input logic p31,
                                   input logic p45, input logic p75);
    logic v;
    v = 1'b0;
    case (sel)
      IPR_LIN_P3_1: v = p31;
      IPR_LIN_P4_5: v = p45;
      IPR_LIN_P7_5: v = p75;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  function automatic logic serialPick(input logic sel, input logic p1, input logic p4);
    return sel ? p4 : p1;
  endfunction

  // ==========================================================================
  // Bus request and decode
  ipr_bus_req_s busReq;
  assign busReq = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};

  logic hitPullup;
  logic hitSerial;
  logic hitLin;
  assign hitPullup = busReq.addr == PULLUP_LOW_ADDR;
  assign hitSerial = busReq.addr == SERIAL_ROUTE_ADDR;
  assign hitLin = busReq.addr == LIN_ROUTE_ADDR;

  logic wrPullup;
  logic wrSerial;
  logic wrLin;
  assign wrPullup = ce && busReq.wr && hitPullup;
  assign wrSerial = ce && busReq.wr && hitSerial;
  assign wrLin = ce && busReq.wr && hitLin;

  // ==========================================================================
  // Configuration registers
  ipr_cfg_s cfg_r;
  ipr_cfg_s cfg_nxt;

  // Reserved bits are stored as written; software is expected to keep them zero.
  always_comb begin
    cfg_nxt = cfg_r;
    if (wrSerial) begin
      cfg_nxt.serialSel = busReq.wdata[SERIAL_SEL_BIT];
      cfg_nxt.serialRsv = busReq.wdata[SERIAL_RSV_BIT];
    end
    if (wrLin) begin
      cfg_nxt.linSel = ipr_lin_sel_e'(busReq.wdata[LIN_SEL_HI:LIN_SEL_LO]);
      cfg_nxt.linRsv = busReq.wdata[LIN_RSV_HI:LIN_RSV_LO];
    end
    if (wrPullup) begin
      cfg_nxt.pullupCtl = busReq.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_r.serialSel <= SERIAL_ROUTE_RESET[SERIAL_SEL_BIT];
      cfg_r.serialRsv <= SERIAL_ROUTE_RESET[SERIAL_RSV_BIT];
      cfg_r.linSel <= ipr_lin_sel_e'(LIN_ROUTE_RESET[LIN_SEL_HI:LIN_SEL_LO]);
      cfg_r.linRsv <= LIN_ROUTE_RESET[LIN_RSV_HI:LIN_RSV_LO];
      cfg_r.pullupCtl <= PULLUP_LOW_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ==========================================================================
  // Read path
  // Unimplemented bits read as zero, which is one of the values allowed.
  logic [DATA_W-1:0] serialReadVal;
  logic [DATA_W-1:0] linReadVal;
  logic [DATA_W-1:0] readSel;
  logic [DATA_W-1:0] busRdata_r;
  logic [DATA_W-1:0] busRdata_nxt;

  assign serialReadVal = SERIAL_IMPL_MASK &
    ((DATA_W'(cfg_r.serialSel) << SERIAL_SEL_BIT) |
     (DATA_W'(cfg_r.serialRsv) << SERIAL_RSV_BIT));
  assign linReadVal = LIN_IMPL_MASK &
    ((DATA_W'(cfg_r.linSel) << LIN_SEL_LO) |
     (DATA_W'(cfg_r.linRsv) << LIN_RSV_LO));

  always_comb begin
    if (hitPullup) begin
      readSel = cfg_r.pullupCtl;
    end else if (hitSerial) begin
      readSel = serialReadVal;
    end else if (hitLin) begin
      readSel = linReadVal;
    end else begin
      readSel = READ_IDLE;
    end
  end

  // Data is shown only in the cycle after the strobe; otherwise the bus is idle.
  assign busRdata_nxt = busReq.rd ? readSel : READ_IDLE;

  always_ff @(posedge clock) begin
    if (rst) begin
      busRdata_r <= READ_IDLE;
    end else if (ce) begin
      busRdata_r <= busRdata_nxt;
    end
  end

  assign busRdata = busRdata_r;

  // ==========================================================================
  // Input routing
  // The routed inputs are retimed once; this costs a cycle but keeps the
  // peripheral free of the mux glitch when software flips the selector.
  logic serialBusInput_r;
  logic serialBusInput_nxt;
  logic linReceiveInput_r;
  logic linReceiveInput_nxt;

  assign serialBusInput_nxt = serialPick(cfg_r.serialSel, serialInPort1,
                                         serialInPort4);
  assign linReceiveInput_nxt = linPick(cfg_r.linSel, linRxPort3Pin1, linRxPort4Pin5,
                                       linRxPort7Pin5);

  always_ff @(posedge clock) begin
    if (rst) begin
      serialBusInput_r <= 1'b0;
      linReceiveInput_r <= 1'b0;
    end else if (ce) begin
      serialBusInput_r <= serialBusInput_nxt;
      linReceiveInput_r <= linReceiveInput_nxt;
    end
  end

  assign serialBusInput = serialBusInput_r;
  assign linReceiveInput = linReceiveInput_r;

  // ==========================================================================
  // Pull-up groups
  ipr_pullup_groups uPullup (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .groupCtl(cfg_r.pullupCtl),
    .portDir(portDir),
    .pullupEnable(pullupEnable)
  );

  // ==========================================================================
  // Checks
  sequence s_serialSet(logic v);
    ce && busWr && busAddr == SERIAL_ROUTE_ADDR && busWdata[SERIAL_SEL_BIT] == v;
  endsequence

  sequence s_linSet(logic [1:0] v);
    ce && busWr && busAddr == LIN_ROUTE_ADDR && busWdata[LIN_SEL_HI:LIN_SEL_LO] == v;
  endsequence

  sequence s_quietTick;
    ce && !busWr;
  endsequence

  property p_serialRoute(logic v);
    @(posedge clock) disable iff (rst)
      s_serialSet(v) ##1 s_quietTick |=>
        serialBusInput == (v ? $past(serialInPort4) : $past(serialInPort1));
  endproperty

  a_serial_route_port1: assert property (p_serialRoute(1'b0))
    else $error("Serial-bus input not taken from port one.");

  a_serial_route_port4: assert property (p_serialRoute(1'b1))
    else $error("Serial-bus input not taken from port four.");

  property p_linRoute(logic [1:0] v);
    @(posedge clock) disable iff (rst)
      s_linSet(v) ##1 s_quietTick |=>
        linReceiveInput == (v == 2'b00 ? $past(linRxPort3Pin1) :
                            v == 2'b01 ? $past(linRxPort4Pin5) : $past(linRxPort7Pin5));
  endproperty

  a_lin_route_p31: assert property (p_linRoute(2'b00))
    else $error("LIN receive input not taken from port 3 bit 1.");

  a_lin_route_p45: assert property (p_linRoute(2'b01))
    else $error("LIN receive input not taken from port 4 bit 5.");

  a_lin_route_p75: assert property (p_linRoute(2'b10))
    else $error("LIN receive input not taken from port 7 bit 5.");

  a_upper_read_zero: assert property (@(posedge clock) disable iff (rst)
    ce && busRd && (busAddr == SERIAL_ROUTE_ADDR || busAddr == LIN_ROUTE_ADDR) |=>
      (busRdata & ~($past(busAddr) == SERIAL_ROUTE_ADDR ? SERIAL_IMPL_MASK : LIN_IMPL_MASK)) ==
      READ_IDLE)
    else $error("Unimplemented routing bits read nonzero.");

  a_route_isolate_serial: assert property (@(posedge clock) disable iff (rst)
    ce && !cfg_r.serialSel && !busWr ##1 ce && $stable(serialInPort1) |=>
      $stable(serialBusInput))
    else $error("Unselected port four disturbs serial-bus input.");

  a_route_isolate_lin: assert property (@(posedge clock) disable iff (rst)
    ce && cfg_r.linSel == IPR_LIN_P7_5 && !busWr ##1 ce && $stable(linRxPort7Pin5) |=>
      $stable(linReceiveInput))
    else $error("Unselected pin disturbs LIN receive input.");

  a_read_one_cycle: assert property (@(posedge clock) disable iff (rst)
    ce && busRd && busAddr == PULLUP_LOW_ADDR ##1 ce && !busRd |=>
      busRdata == READ_IDLE)
    else $error("Read data held longer than one cycle.");

  // ==========================================================================
  // Register and freeze checks
  // Storage is watched directly as well as through the read port, so a lost
  // write cannot hide behind a read mux that happens to return the same value.
  sequence s_regWrite(logic [ADDR_W-1:0] a);
    ce && busWr && busAddr == a;
  endsequence

  sequence s_regRead(logic [ADDR_W-1:0] a);
    ce && busRd && busAddr == a;
  endsequence

  sequence s_unmappedWrite;
    ce && busWr && !hitPullup && !hitSerial && !hitLin;
  endsequence

  sequence s_unmappedRead;
    ce && busRd && !hitPullup && !hitSerial && !hitLin;
  endsequence

  a_pullup_write_lands: assert property (@(posedge clock) disable iff (rst)
    s_regWrite(PULLUP_LOW_ADDR) |=> cfg_r.pullupCtl == $past(busWdata))
    else $error("Pull-up control write did not land.");

  a_serial_write_lands: assert property (@(posedge clock) disable iff (rst)
    s_regWrite(SERIAL_ROUTE_ADDR) |=> cfg_r.serialSel == $past(busWdata[SERIAL_SEL_BIT]))
    else $error("Serial-bus route write did not land.");

  a_lin_write_lands: assert property (@(posedge clock) disable iff (rst)
    s_regWrite(LIN_ROUTE_ADDR) |=>
      {cfg_r.linRsv, cfg_r.linSel} == $past(busWdata[LIN_RSV_HI:LIN_SEL_LO]))
    else $error("LIN receive route write did not land.");

  a_pullup_read_back: assert property (@(posedge clock) disable iff (rst)
    s_regRead(PULLUP_LOW_ADDR) |=> busRdata == $past(cfg_r.pullupCtl))
    else $error("Pull-up control read returned the wrong value.");

  a_serial_read_back: assert property (@(posedge clock) disable iff (rst)
    s_regRead(SERIAL_ROUTE_ADDR) |=> busRdata[SERIAL_SEL_BIT] == $past(cfg_r.serialSel) &&
      busRdata[SERIAL_RSV_BIT] == $past(cfg_r.serialRsv))
    else $error("Serial-bus route read returned the wrong value.");

  a_lin_read_back: assert property (@(posedge clock) disable iff (rst)
    s_regRead(LIN_ROUTE_ADDR) |=>
      busRdata == DATA_W'($past({cfg_r.linRsv, cfg_r.linSel})))
    else $error("LIN receive route read returned the wrong value.");

  a_unmapped_write_ignored: assert property (@(posedge clock) disable iff (rst)
    s_unmappedWrite |=> $stable(cfg_r))
    else $error("Write to an unmapped address changed a register.");

  a_unmapped_read_idle: assert property (@(posedge clock) disable iff (rst)
    s_unmappedRead |=> busRdata == READ_IDLE)
    else $error("Read of an unmapped address returned data.");

  a_freeze_state: assert property (@(posedge clock) disable iff (rst)
    !ce |=> $stable(cfg_r) && $stable(busRdata) && $stable(serialBusInput) &&
      $stable(linReceiveInput) && $stable(pullupEnable))
    else $error("State moved while the clock enable was low.");

  // Reset wins over the clock enable, so no enable term appears here.
  a_reset_clears: assert property (@(posedge clock)
    rst |=> busRdata == READ_IDLE && !serialBusInput && !linReceiveInput &&
      pullupEnable == '0 && cfg_r.pullupCtl == PULLUP_LOW_RESET)
    else $error("Reset did not clear the outputs.");

endmodule // ipr_input_route

// file: sim/ipr_input_route_test.sv
`timescale 1ns/1ps
module ipr_input_route_test;
  import ipr_pkg::*;

  // ==========================================================================
  // Stimulus table
  typedef struct packed {
    logic ser;
    logic [1:0] lin;
    logic [4:0] pins;
    logic expSer;
    logic expLin;
  } ipr_row_s;

  // Pins are ordered port-one, port-four, P3 bit1, P4 bit5, P7 bit5.
  // Each row drives the unselected pins opposite to the selected one.
  ipr_row_s rows [6] = '{
    '{1'b0, 2'h0, 5'h14, 1'b1, 1'b1},
    '{1'b0, 2'h0, 5'h0B, 1'b0, 1'b0},
    '{1'b1, 2'h1, 5'h0A, 1'b1, 1'b1},
    '{1'b1, 2'h1, 5'h15, 1'b0, 1'b0},
    '{1'b1, 2'h2, 5'h09, 1'b1, 1'b1},
    '{1'b1, 2'h2, 5'h16, 1'b0, 1'b0}
  };

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] busAddr = '0;
  logic [DATA_W-1:0] busWdata = '0;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic [DATA_W-1:0] busRdata;
  logic [4:0] pins = '0;
  logic [PORT_PIN_CNT-1:0] portDir = '0;
  logic [PORT_PIN_CNT-1:0] dirPat;
  logic [DATA_W-1:0] ctl;
  logic serialBusInput;
  logic linReceiveInput;
  logic [PORT_PIN_CNT-1:0] pullupEnable;
  int miscompares = 0;
  int comparisons = 0;

  ipr_input_route u_dut (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .busAddr(busAddr),
    .busWdata(busWdata),
    .busWr(busWr),
    .busRd(busRd),
    .busRdata(busRdata),
    .serialInPort1(pins[4]),
    .serialInPort4(pins[3]),
    .linRxPort3Pin1(pins[2]),
    .linRxPort4Pin5(pins[1]),
    .linRxPort7Pin5(pins[0]),
    .portDir(portDir),
    .serialBusInput(serialBusInput),
    .linReceiveInput(linReceiveInput),
    .pullupEnable(pullupEnable)
  );

  initial begin
    forever #20 clock = ~clock;
  end

  // ==========================================================================
  // Helpers
  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus tasks are entered just after a rising edge and leave just after one.
  // A write lets one idle edge pass, so two writes never drive the strobe twice at once.
  task automatic busWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    @(posedge clock);
    busWr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic busRead(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge clock);
    busRd <= 1'b0;
    #1;
    chk(busRdata, exp);
    @(posedge clock);
  endtask

  // Reference for the pull-up path, worked out pin by pin.
  function automatic logic [31:0] expPull(input logic [7:0] c, input logic [31:0] d);
    logic [31:0] e;
    for (int i = 0; i < 32; i++) begin
      e[i] = c[i / 4] & ~d[i];
    end
    return e;
  endfunction

  // ==========================================================================
  // Tests
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(pullupEnable, 32'h0000_0000);
    @(posedge clock);
    busRead(PULLUP_LOW_ADDR, PULLUP_LOW_RESET);
    busRead(LIN_ROUTE_ADDR, LIN_ROUTE_RESET);
    busRead(SERIAL_ROUTE_ADDR, SERIAL_ROUTE_RESET);
    for (int r = 0; r < 6; r++) begin
      busWrite(SERIAL_ROUTE_ADDR, {7'h00, rows[r].ser});
      busWrite(LIN_ROUTE_ADDR, {6'h00, rows[r].lin});
      pins <= rows[r].pins;
      repeat (2) @(posedge clock);
      #1;
      chk(serialBusInput, rows[r].expSer);
      chk(linReceiveInput, rows[r].expLin);
      @(posedge clock);
    end
    // One bit at a time proves the group mapping, then all groups at once.
    for (int g = 0; g < 9; g++) begin
      ctl = (g < 8) ? (8'h01 << g) : 8'hFF;
      dirPat = g[0] ? 32'hA5C3_0F96 : 32'h5A3C_F069;
      busWrite(PULLUP_LOW_ADDR, ctl);
      portDir <= dirPat;
      repeat (2) @(posedge clock);
      #1;
      chk(pullupEnable, expPull(ctl, dirPat));
      @(posedge clock);
      busRead(PULLUP_LOW_ADDR, ctl);
    end
    busWrite(SERIAL_ROUTE_ADDR, 8'h01);
    busRead(SERIAL_ROUTE_ADDR, 8'h01);
    busWrite(LIN_ROUTE_ADDR, 8'h02);
    busRead(LIN_ROUTE_ADDR, 8'h02);
    // Bits one and seven land on the upper halves of ports zero and three.
    portDir <= '0;
    busWrite(PULLUP_LOW_ADDR, 8'h82);
    repeat (2) @(posedge clock);
    #1;
    chk(pullupEnable, 32'hF000_00F0);
    @(posedge clock);
    busWrite(PULLUP_LOW_ADDR, 8'h5A);
    busWrite(20'h003F1, 8'hFF);
    busRead(20'h003F1, READ_IDLE);
    busRead(PULLUP_LOW_ADDR, 8'h5A);
    // With the clock enable low a write and new pin levels must change nothing.
    ce <= 1'b0;
    pins <= 5'h0F;
    busWrite(PULLUP_LOW_ADDR, 8'h00);
    #1;
    chk(serialBusInput, 1'b0);
    chk(linReceiveInput, 1'b0);
    ce <= 1'b1;
    busRead(PULLUP_LOW_ADDR, 8'h5A);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(pullupEnable, 32'h0000_0000);
    @(posedge clock);
    busRead(PULLUP_LOW_ADDR, PULLUP_LOW_RESET);
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    stop_test();
  end

endmodule // ipr_input_route_test
